// >>> uart_consts.svh
/*
  Constants of the serial channel register block: offsets, field positions,
  reset values and structural sizes.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_DATA 3'h0
`define OFS_INT_EN 3'h1
`define OFS_INT_ID 3'h2
`define OFS_LINE_CTL 3'h3
`define OFS_MODEM_CTL 3'h4
`define OFS_LINE_STAT 3'h5
`define OFS_MODEM_STAT 3'h6
`define OFS_SCRATCH 3'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IE_RX_AVAIL 0
`define IE_TX_EMPTY 1
`define IE_LINE_STAT 2
`define IE_MODEM_STAT 3
`define LC_STOP_LONG 2
`define LC_BREAK 6
`define LC_DIV_ACCESS 7
`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT1 2
`define MC_OUT2 3

// ----------------------------------------------------------------------
// Identification codes and reset values
// ----------------------------------------------------------------------
`define ID_NONE 8'h01
`define ID_LINE 8'h06
`define ID_RX_DATA 8'h04
`define ID_TX_EMPTY 8'h02
`define ID_MODEM 8'h00
`define RST_INT_EN 4'h0
`define RST_BYTE 8'h00
`define RST_MODEM_CTL 5'h00
`define RST_PINS 19'h7ffff

// ----------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------
`define TX_FIFO_WIDTH 8
`define TX_FIFO_DEPTH 16

`endif

// >>> uart_types_pkg.sv
/*
  Types shared by the serial channel register block.
  Assumes nothing of its surroundings.
*/
package uart_types_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] reg_addr_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : uart_types_pkg

// >>> fifo_buf.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock, an active-low asynchronous reset and a clock enable.
*/
`timescale 1ns/1ps
module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic push, pop;

  always_comb begin
    in_ready = (wr_ptr_q[AW] == rd_ptr_q[AW]) || (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
    out_valid = (wr_ptr_q != rd_ptr_q);
    out_data = mem_q[rd_ptr_q[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_d = push ? wr_ptr_q + (AW+1)'(1) : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + (AW+1)'(1) : rd_ptr_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (clk_en) begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Storage needs no reset; only words below the write pointer are read
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : fifo_buf

// >>> serial_shift.sv
/*
  Transmit and receive shifters of the serial channel, one bit time equal to
  the divisor in clock cycles.
  Assumes rx_line is already synchronised and the feed is a valid/ready source.
*/
`timescale 1ns/1ps
`include "uart_consts.svh"
module serial_shift (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Line format
  input wire logic [15:0] divisor,
  input wire logic [1:0] word_len,
  input wire logic stop_long,
  input wire logic break_en,
  // Transmit feed
  input wire logic tx_valid,
  output logic tx_ready,
  input wire uart_types_pkg::byte_t tx_data,
  output logic tx_busy,
  // Receive result
  input wire logic rx_line,
  output logic rx_strobe,
  output uart_types_pkg::byte_t rx_data,
  output logic rx_frame_err,
  output logic rx_break,
  // Serial output
  output logic sout
);
  import uart_types_pkg::*;

  function automatic logic tick_done(input logic [16:0] tmr);
    return tmr == 17'h00001;
  endfunction : tick_done

  tx_state_t tx_st_q, tx_st_d;
  rx_state_t rx_st_q, rx_st_d;
  logic [16:0] tx_tmr_q, tx_tmr_d, rx_tmr_q, rx_tmr_d, bit_len, stop_len;
  logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d, last_bit;
  byte_t tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_data_d;
  logic line, sout_d, rx_strobe_d, rx_fe_d, rx_bi_d;

  always_comb begin
    // A zero divisor would stall the shifters, so it acts as one
    bit_len = {1'b0, (divisor == 16'h0000) ? 16'h0001 : divisor};
    stop_len = !stop_long ? bit_len :
               (word_len == 2'h0) ? bit_len + (bit_len >> 1) : bit_len << 1;
    last_bit = 3'h4 + {1'b0, word_len};
    tx_ready = (tx_st_q == TX_IDLE);
    tx_busy = !tx_ready;
    tx_st_d = tx_st_q;
    tx_tmr_d = tick_done(tx_tmr_q) ? tx_tmr_q : tx_tmr_q - 17'h00001;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    line = 1'b1;
    case (tx_st_q)
      TX_IDLE: begin
        if (tx_valid) begin
          tx_sh_d = tx_data;
          tx_tmr_d = bit_len;
          tx_st_d = TX_START;
        end
      end
      TX_START: begin
        line = 1'b0;
        if (tick_done(tx_tmr_q)) begin
          tx_tmr_d = bit_len;
          tx_bit_d = 3'h0;
          tx_st_d = TX_DATA;
        end
      end
      TX_DATA: begin
        line = tx_sh_q[0];
        if (tick_done(tx_tmr_q)) begin
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = tx_bit_q + 3'h1;
          tx_tmr_d = (tx_bit_q == last_bit) ? stop_len : bit_len;
          tx_st_d = (tx_bit_q == last_bit) ? TX_STOP : TX_DATA;
        end
      end
      TX_STOP: begin
        if (tick_done(tx_tmr_q)) begin
          tx_st_d = TX_IDLE;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
    sout_d = line && !break_en;
  end

  always_comb begin
    rx_st_d = rx_st_q;
    rx_tmr_d = tick_done(rx_tmr_q) ? rx_tmr_q : rx_tmr_q - 17'h00001;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_strobe_d = 1'b0;
    rx_data_d = rx_data;
    rx_fe_d = rx_frame_err;
    rx_bi_d = rx_break;
    case (rx_st_q)
      RX_IDLE: begin
        if (!rx_line) begin
          rx_tmr_d = (bit_len > 17'h00001) ? bit_len >> 1 : 17'h00001;
          rx_st_d = RX_START;
        end
      end
      RX_START: begin
        if (tick_done(rx_tmr_q)) begin
          rx_tmr_d = bit_len;
          rx_bit_d = 3'h0;
          rx_st_d = rx_line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (tick_done(rx_tmr_q)) begin
          rx_sh_d = {rx_line, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          rx_tmr_d = bit_len;
          rx_st_d = (rx_bit_q == last_bit) ? RX_STOP : RX_DATA;
        end
      end
      RX_STOP: begin
        if (tick_done(rx_tmr_q)) begin
          rx_strobe_d = 1'b1;
          rx_data_d = rx_sh_q >> (3'h3 - {1'b0, word_len});
          rx_fe_d = !rx_line;
          rx_bi_d = !rx_line && (rx_data_d == 8'h00);
          rx_st_d = RX_IDLE;
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_q <= TX_IDLE;
      tx_tmr_q <= 17'h00001;
      tx_bit_q <= 3'h0;
      tx_sh_q <= `RST_BYTE;
      sout <= 1'b1;
      rx_st_q <= RX_IDLE;
      rx_tmr_q <= 17'h00001;
      rx_bit_q <= 3'h0;
      rx_sh_q <= `RST_BYTE;
      rx_strobe <= 1'b0;
      rx_data <= `RST_BYTE;
      rx_frame_err <= 1'b0;
      rx_break <= 1'b0;
    end else if (clk_en) begin
      tx_st_q <= tx_st_d;
      tx_tmr_q <= tx_tmr_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      sout <= sout_d;
      rx_st_q <= rx_st_d;
      rx_tmr_q <= rx_tmr_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_strobe <= rx_strobe_d;
      rx_data <= rx_data_d;
      rx_frame_err <= rx_fe_d;
      rx_break <= rx_bi_d;
    end
  end
endmodule : serial_shift

// >>> uart_regs.sv
/*
  Register map of one asynchronous serial channel with its interrupt enable
  and identification logic, transmit FIFO and shifters.
  Assumes the CPU bus pins, modem pins and serial input are asynchronous to
  sys_clk and that strobes last several clock cycles.
*/
`timescale 1ns/1ps
`include "uart_consts.svh"
module uart_regs (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // CPU register bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire uart_types_pkg::reg_addr_t addr,
  input wire uart_types_pkg::byte_t data_in,
  output uart_types_pkg::byte_t data_out,
  output logic data_oe,
  // Serial line
  input wire logic sin,
  output logic sout,
  // Modem inputs
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  // Modem outputs
  output logic dtr_n,
  output logic rts_n,
  output logic out1_n,
  output logic out2_n,
  // Interrupt
  output logic irq_out
);
  import uart_types_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic fell(input logic was, input logic now);
    return was && !now;
  endfunction : fell

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // All bus, modem and serial input pins share three stages; a bit moves only when stages two
  // and three agree, which hides a single metastable sample.
  logic [18:0] pins, sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  logic f_cs_n, f_rd_n, f_wr_n, f_cts_n, f_dsr_n, f_ri_n, f_dcd_n, f_sin;
  reg_addr_t f_addr;
  byte_t f_data;

  always_comb begin
    pins = {cs_n, rd_n, wr_n, addr, data_in, cts_n, dsr_n, ri_n, dcd_n, sin};
    filt_d = (sync3_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
    {f_cs_n, f_rd_n, f_wr_n, f_addr, f_data, f_cts_n, f_dsr_n, f_ri_n, f_dcd_n, f_sin} = filt_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= `RST_PINS;
      sync2_q <= `RST_PINS;
      sync3_q <= `RST_PINS;
      filt_q <= `RST_PINS;
    end else if (clk_en) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [3:0] int_enable_q, int_enable_d;
  byte_t line_control_q, line_control_d, scratch_q, scratch_d;
  byte_t divisor_low_q, divisor_low_d, divisor_high_q, divisor_high_d;
  logic [4:0] modem_control_q, modem_control_d;
  byte_t rx_buffer_q, rx_buffer_d;
  logic data_ready_q, data_ready_d, overrun_q, overrun_d;
  logic frame_err_q, frame_err_d, break_q, break_d;
  logic [3:0] modem_delta_q, modem_delta_d, modem_prev_q, modem_prev_d;
  logic tx_pend_q, tx_pend_d, tx_empty_prev_q, tx_empty;
  logic src_line, src_rx, src_tx, src_modem, any_pending;
  byte_t ident;
  logic rd_prev_q, wr_prev_q, rd_go, wr_go, div_access;
  logic rd_rx_buf, rd_ident, rd_lstat, rd_mstat;
  logic wr_tx, wr_div_lo, wr_div_hi, wr_ie, wr_lc, wr_mc, wr_scr;

  always_comb begin
    // Reads act at the start of the strobe, writes at its end when data is settled
    rd_go = fell(rd_prev_q, f_rd_n) && !f_cs_n;
    wr_go = fell(f_wr_n, wr_prev_q) && !f_cs_n;
    div_access = line_control_q[`LC_DIV_ACCESS];
    rd_rx_buf = rd_go && (f_addr == `OFS_DATA) && !div_access;
    rd_ident = rd_go && (f_addr == `OFS_INT_ID);
    rd_lstat = rd_go && (f_addr == `OFS_LINE_STAT);
    rd_mstat = rd_go && (f_addr == `OFS_MODEM_STAT);
    wr_tx = wr_go && (f_addr == `OFS_DATA) && !div_access;
    wr_div_lo = wr_go && (f_addr == `OFS_DATA) && div_access;
    wr_div_hi = wr_go && (f_addr == `OFS_INT_EN) && div_access;
    wr_ie = wr_go && (f_addr == `OFS_INT_EN) && !div_access;
    wr_lc = wr_go && (f_addr == `OFS_LINE_CTL);
    wr_mc = wr_go && (f_addr == `OFS_MODEM_CTL);
    wr_scr = wr_go && (f_addr == `OFS_SCRATCH);
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  logic fifo_in_ready, fifo_out_valid, shift_ready, tx_busy;
  byte_t fifo_out_data;
  logic rx_strobe, rx_frame_err, rx_break;
  byte_t rx_data;

  // A write that finds the FIFO full is dropped; software polls the empty flag
  fifo_buf #(
    .WIDTH(`TX_FIFO_WIDTH),
    .DEPTH(`TX_FIFO_DEPTH)
  ) tx_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(wr_tx),
    .in_ready(fifo_in_ready),
    .in_data(f_data),
    .out_valid(fifo_out_valid),
    .out_ready(shift_ready),
    .out_data(fifo_out_data)
  );

  serial_shift shifter (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .divisor({divisor_high_q, divisor_low_q}),
    .word_len(line_control_q[1:0]),
    .stop_long(line_control_q[`LC_STOP_LONG]),
    .break_en(line_control_q[`LC_BREAK]),
    .tx_valid(fifo_out_valid),
    .tx_ready(shift_ready),
    .tx_data(fifo_out_data),
    .tx_busy(tx_busy),
    .rx_line(f_sin),
    .rx_strobe(rx_strobe),
    .rx_data(rx_data),
    .rx_frame_err(rx_frame_err),
    .rx_break(rx_break),
    .sout(sout)
  );

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  always_comb begin
    tx_empty = !fifo_out_valid;
    int_enable_d = wr_ie ? f_data[3:0] : int_enable_q;
    line_control_d = wr_lc ? f_data : line_control_q;
    divisor_low_d = wr_div_lo ? f_data : divisor_low_q;
    divisor_high_d = wr_div_hi ? f_data : divisor_high_q;
    modem_control_d = wr_mc ? f_data[4:0] : modem_control_q;
    scratch_d = wr_scr ? f_data : scratch_q;
    rx_buffer_d = rx_strobe ? rx_data : rx_buffer_q;
    // New events win over the clearing read in the same cycle
    data_ready_d = rx_strobe || (data_ready_q && !rd_rx_buf);
    overrun_d = (rx_strobe && data_ready_q && !rd_rx_buf) || (overrun_q && !rd_lstat);
    frame_err_d = (rx_strobe && rx_frame_err) || (frame_err_q && !rd_lstat);
    break_d = (rx_strobe && rx_break) || (break_q && !rd_lstat);
    modem_prev_d = {f_dcd_n, f_ri_n, f_dsr_n, f_cts_n};
    modem_delta_d[0] = (f_cts_n != modem_prev_q[0]) || (modem_delta_q[0] && !rd_mstat);
    modem_delta_d[1] = (f_dsr_n != modem_prev_q[1]) || (modem_delta_q[1] && !rd_mstat);
    modem_delta_d[2] = fell(f_ri_n, modem_prev_q[2]) || (modem_delta_q[2] && !rd_mstat);
    modem_delta_d[3] = (f_dcd_n != modem_prev_q[3]) || (modem_delta_q[3] && !rd_mstat);
    // Holding-empty pends on the FIFO draining; cleared by a new write or by
    // reading the ident while it is the reported source
    if (tx_empty && !tx_empty_prev_q) begin
      tx_pend_d = 1'b1;
    end else if (wr_tx || (rd_ident && ident == `ID_TX_EMPTY)) begin
      tx_pend_d = 1'b0;
    end else begin
      tx_pend_d = tx_pend_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_enable_q <= `RST_INT_EN;
      line_control_q <= `RST_BYTE;
      divisor_low_q <= `RST_BYTE;
      divisor_high_q <= `RST_BYTE;
      modem_control_q <= `RST_MODEM_CTL;
      scratch_q <= `RST_BYTE;
      rx_buffer_q <= `RST_BYTE;
      data_ready_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_err_q <= 1'b0;
      break_q <= 1'b0;
      modem_prev_q <= 4'hf;
      modem_delta_q <= 4'h0;
      tx_pend_q <= 1'b0;
      tx_empty_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else if (clk_en) begin
      int_enable_q <= int_enable_d;
      line_control_q <= line_control_d;
      divisor_low_q <= divisor_low_d;
      divisor_high_q <= divisor_high_d;
      modem_control_q <= modem_control_d;
      scratch_q <= scratch_d;
      rx_buffer_q <= rx_buffer_d;
      data_ready_q <= data_ready_d;
      overrun_q <= overrun_d;
      frame_err_q <= frame_err_d;
      break_q <= break_d;
      modem_prev_q <= modem_prev_d;
      modem_delta_q <= modem_delta_d;
      tx_pend_q <= tx_pend_d;
      tx_empty_prev_q <= tx_empty;
      rd_prev_q <= f_rd_n;
      wr_prev_q <= f_wr_n;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt sources and identification
  // ----------------------------------------------------------------------
  always_comb begin
    src_line = int_enable_q[`IE_LINE_STAT] && (overrun_q || frame_err_q || break_q);
    src_rx = int_enable_q[`IE_RX_AVAIL] && data_ready_q;
    src_tx = int_enable_q[`IE_TX_EMPTY] && tx_pend_q;
    src_modem = int_enable_q[`IE_MODEM_STAT] && (modem_delta_q != 4'h0);
    any_pending = src_line || src_rx || src_tx || src_modem;
    if (src_line) begin
      ident = `ID_LINE;
    end else if (src_rx) begin
      ident = `ID_RX_DATA;
    end else if (src_tx) begin
      ident = `ID_TX_EMPTY;
    end else if (src_modem) begin
      ident = `ID_MODEM;
    end else begin
      ident = `ID_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Read data and pin outputs
  // ----------------------------------------------------------------------
  byte_t read_mux, data_out_d;
  logic data_oe_d, irq_d, dtr_n_d, rts_n_d, out1_n_d, out2_n_d;

  always_comb begin
    case (f_addr)
      `OFS_DATA: read_mux = div_access ? divisor_low_q : rx_buffer_q;
      `OFS_INT_EN: read_mux = div_access ? divisor_high_q : {4'h0, int_enable_q};
      `OFS_INT_ID: read_mux = ident;
      `OFS_LINE_CTL: read_mux = line_control_q;
      `OFS_MODEM_CTL: read_mux = {3'h0, modem_control_q};
      `OFS_LINE_STAT: read_mux = {1'b0, tx_empty && !tx_busy, tx_empty, break_q,
                                  frame_err_q, 1'b0, overrun_q, data_ready_q};
      `OFS_MODEM_STAT: read_mux = {~f_dcd_n, ~f_ri_n, ~f_dsr_n, ~f_cts_n, modem_delta_q};
      default: read_mux = scratch_q;
    endcase
    data_out_d = rd_go ? read_mux : data_out;
    // Drive only while a selected read strobe is seen low
    data_oe_d = !f_rd_n && !f_cs_n;
    irq_d = any_pending;
    dtr_n_d = !modem_control_d[`MC_DTR];
    rts_n_d = !modem_control_d[`MC_RTS];
    out1_n_d = !modem_control_d[`MC_OUT1];
    out2_n_d = !modem_control_d[`MC_OUT2];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= `RST_BYTE;
      data_oe <= 1'b0;
      irq_out <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      out1_n <= 1'b1;
      out2_n <= 1'b1;
    end else if (clk_en) begin
      data_out <= data_out_d;
      data_oe <= data_oe_d;
      irq_out <= irq_d;
      dtr_n <= dtr_n_d;
      rts_n <= rts_n_d;
      out1_n <= out1_n_d;
      out2_n <= out2_n_d;
    end
  end
endmodule : uart_regs

// >>> host_cpu.sv
/*
  Host CPU model on the register bus pins, with write and read tasks.
  Assumes the device filters each pin for about 4 clock cycles.
*/
`timescale 1ns/1ps
module host_cpu (
  // Clock
  input wire logic sys_clk,
  // Register bus
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output uart_types_pkg::reg_addr_t addr,
  output uart_types_pkg::byte_t data_in,
  input wire uart_types_pkg::byte_t data_out,
  input wire logic data_oe
);
  import uart_types_pkg::*;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
  end
  // Every change lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic bus_write(input reg_addr_t a, input byte_t d);
    cs_n = 1'b0;
    addr = a;
    data_in = d;
    wr_n = 1'b0;
    tick(6);
    wr_n = 1'b1;
    tick(6);
    cs_n = 1'b1;
    // Released pins show the inverse, never the old value
    addr = ~a;
    data_in = ~d;
    tick(6);
  endtask : bus_write
  task automatic bus_read(input reg_addr_t a, output byte_t d);
    cs_n = 1'b0;
    addr = a;
    tick(4);
    rd_n = 1'b0;
    tick(9);
    d = data_oe ? data_out : 8'hxx;
    rd_n = 1'b1;
    tick(6);
    cs_n = 1'b1;
    addr = ~a;
    tick(6);
  endtask : bus_read
endmodule : host_cpu

// >>> uart_regs_asserts.sv
/*
  Port checker for uart_regs.
  Assumes it is bound to every uart_regs instance.
*/
`timescale 1ns/1ps
module uart_regs_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire uart_types_pkg::byte_t data_out,
  input wire logic data_oe,
  // Outputs
  input wire logic sout,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic out1_n,
  input wire logic out2_n,
  input wire logic irq_out
);
  import uart_types_pkg::*;
  logic wr_seen_q, wr_seen_d;
  logic [3:0] quiet_q, quiet_d;
  always_comb begin
    wr_seen_d = wr_seen_q | (!wr_n & !cs_n);
    quiet_d = (!rd_n | !wr_n) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_seen_q <= 1'b0;
      quiet_q <= 4'hf;
    end else begin
      wr_seen_q <= wr_seen_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence rd_held; (!cs_n && !rd_n) [*8]; endsequence
  sequence rd_idle; rd_n [*8]; endsequence
  rd_answer_a: assert property (rd_held |-> data_oe)
    else $error("read strobe got no data");
  oe_cause_a: assert property ($rose(data_oe) |-> !$past(rd_n, 3) && !$past(cs_n, 3))
    else $error("data driven without a read");
  oe_close_a: assert property (rd_idle |-> !data_oe)
    else $error("data still driven after read");
  out_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("read data moved during read");
  irq_cause_a: assert property (irq_out |-> wr_seen_q)
    else $error("interrupt with no enable written");
  irq_drop_a: assert property ($fell(irq_out) |-> quiet_q < 4'hc)
    else $error("interrupt fell without an access");
  idle_line_a: assert property (!wr_seen_q |-> sout)
    else $error("serial output left idle unprompted");
  modem_idle_a: assert property (!wr_seen_q |-> dtr_n && rts_n && out1_n && out2_n)
    else $error("modem outputs moved unprompted");
endmodule : uart_regs_asserts
bind uart_regs uart_regs_asserts chk (.sys_clk, .reset_n, .cs_n, .rd_n, .wr_n,
  .data_out, .data_oe, .sout, .dtr_n, .rts_n, .out1_n, .out2_n, .irq_out);

// >>> tb_top.sv
/*
  Bench for uart_regs: bus traffic via host_cpu, frames on sin.
  Assumes host_cpu and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`include "uart_consts.svh"
module tb_top;
  import uart_types_pkg::*;
  localparam int DIV = 64;
  logic sys_clk, reset_n, sin, cts_n, cs_n, rd_n, wr_n, data_oe;
  logic sout, dtr_n, rts_n, out1_n, out2_n, irq_out, clk_en, dsr_n, ri_n, dcd_n;
  reg_addr_t addr;
  byte_t data_in, data_out;
  int err_total, n_checks, n_starts;
  uart_regs uut (.sys_clk, .reset_n, .clk_en, .cs_n, .rd_n, .wr_n, .addr,
    .data_in, .data_out, .data_oe, .sin, .sout, .cts_n, .dsr_n, .ri_n,
    .dcd_n, .dtr_n, .rts_n, .out1_n, .out2_n, .irq_out);
  host_cpu cpu (.sys_clk, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // All-ones bytes give exactly one falling edge per character
  always @(negedge sout) if (reset_n === 1'b1) n_starts++;
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rchk(input reg_addr_t a, input byte_t exp, input string what);
    byte_t v;
    cpu.bus_read(a, v);
    chk(what, exp, v);
  endtask : rchk
  task automatic chk_irq(input logic exp);
    chk("irq_out", {7'h00, exp}, {7'h00, irq_out});
  endtask : chk_irq
  task automatic send_frame(input byte_t b);
    sin = 1'b0;
    cpu.tick(DIV);
    for (int i = 0; i < 8; i++) begin
      sin = b[i];
      cpu.tick(DIV);
    end
    sin = 1'b1;
    cpu.tick(DIV);
  endtask : send_frame
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
  initial begin
    err_total = 0;
    n_checks = 0;
    n_starts = 0;
    reset_n = 1'b0;
    sin = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    ri_n = 1'b1;
    dcd_n = 1'b1;
    clk_en = 1'b1;
    cpu.tick(2);
    reset_n = 1'b1;
    cpu.tick(2);
    rchk(`OFS_INT_EN, 8'h00, "int_enable");
    rchk(`OFS_INT_ID, `ID_NONE, "int_ident");
    rchk(`OFS_LINE_STAT, 8'h60, "line_status");
    cpu.bus_write(`OFS_LINE_CTL, 8'h80);
    cpu.bus_write(`OFS_DATA, 8'h40);
    cpu.bus_write(`OFS_INT_EN, 8'h00);
    rchk(`OFS_DATA, 8'h40, "divisor_low");
    cpu.bus_write(`OFS_LINE_CTL, 8'h03);
    cpu.bus_write(`OFS_INT_EN, 8'hff);
    rchk(`OFS_INT_EN, 8'h0f, "int_enable");
    cpu.bus_write(`OFS_MODEM_CTL, 8'h15);
    rchk(`OFS_MODEM_CTL, 8'h15, "modem_control");
    chk("modem_pins", 8'h0a, {4'h0, out2_n, out1_n, rts_n, dtr_n});
    cpu.bus_write(`OFS_SCRATCH, 8'h5a);
    rchk(`OFS_SCRATCH, 8'h5a, "scratch");
    chk_irq(1'b0);
    // Fill: one in the shifter, 16 queued, the rest dropped
    cpu.bus_write(`OFS_INT_EN, 8'h02);
    for (int i = 0; i < 20; i++) cpu.bus_write(`OFS_DATA, 8'hff);
    cpu.tick(11500);
    chk("tx_starts", 8'h11, n_starts[7:0]);
    chk_irq(1'b1);
    rchk(`OFS_INT_ID, `ID_TX_EMPTY, "int_ident");
    chk_irq(1'b0);
    // Two frames unread: data ready plus overrun
    cpu.bus_write(`OFS_INT_EN, 8'h00);
    send_frame(8'h35);
    send_frame(8'hca);
    cpu.tick(DIV);
    chk_irq(1'b0);
    cpu.bus_write(`OFS_INT_EN, 8'h04);
    chk_irq(1'b1);
    rchk(`OFS_INT_ID, `ID_LINE, "int_ident");
    rchk(`OFS_LINE_STAT, 8'h63, "line_status");
    chk_irq(1'b0);
    cpu.bus_write(`OFS_INT_EN, 8'h01);
    chk_irq(1'b1);
    rchk(`OFS_DATA, 8'hca, "rx_buffer");
    chk_irq(1'b0);
    cpu.bus_write(`OFS_INT_EN, 8'h08);
    cts_n = 1'b0;
    cpu.tick(12);
    chk_irq(1'b1);
    rchk(`OFS_INT_ID, `ID_MODEM, "int_ident");
    cpu.bus_write(`OFS_INT_EN, 8'h00);
    chk_irq(1'b0);
    rchk(`OFS_INT_ID, `ID_NONE, "int_ident");
    // Ring delta counts only on the trailing edge
    dsr_n = 1'b0;
    dcd_n = 1'b0;
    ri_n = 1'b0;
    cpu.tick(12);
    ri_n = 1'b1;
    cpu.tick(12);
    rchk(`OFS_MODEM_STAT, 8'hbf, "modem_status");
    cpu.bus_write(`OFS_INT_EN, 8'h08);
    // A frozen block must not see the pin change
    clk_en = 1'b0;
    cts_n = 1'b1;
    cpu.tick(12);
    chk_irq(1'b0);
    clk_en = 1'b1;
    cpu.tick(12);
    chk_irq(1'b1);
    conclude();
  end
endmodule : tb_top
